/* core/mpd_core.sv */
// Mode parameter descriptor core: parses select lists, serves sense data.
// Assumes the header has been stripped by the caller and handed over
// as sel_wide and sel_bd_len with sel_start.
`timescale 1ns/1ns
module mpd_core #(
  parameter int unsigned UNIT_CYCLES = mpd_pkg::UNIT_CYC // Cycles per unit
) (
  input wire logic clk, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [63:0] max_blocks, // Blocks in the data area
  input wire logic sel_start, // Select list begins
  input wire logic sel_wide, // Long descriptor format
  input wire logic [15:0] sel_bd_len, // Descriptor length
  input wire logic sel_valid, // Select byte present
  input wire logic [7:0] sel_data, // Select byte
  input wire logic sel_end, // Select list finished
  output logic sel_done, // Select finished pulse
  output logic sel_chk, // Select ended in check condition
  input wire logic fmt_start, // Format command pulse
  output logic fmt_pending, // Parameters await a format
  output logic [63:0] user_blocks, // Addressable blocks
  output logic [31:0] cur_len, // Block length in use
  input wire logic sense_start, // Sense request pulse
  input wire logic sense_wide, // Long descriptor wanted
  input wire logic sense_no_desc, // Omit descriptor
  input wire logic [5:0] sense_code, // Page requested
  output logic sense_chk, // Unsupported page pulse
  output logic so_valid, // Sense byte present
  output logic [7:0] so_data, // Sense byte
  output logic so_last, // Final sense byte
  input wire logic so_ready, // Sense byte taken
  input wire logic cmd_active, // A command is running
  output logic cmd_abort, // Command overran pulse
  input wire logic queue_wait, // A command waits in queue
  output logic age_expired, // Queue wait over limit
  output logic grown_defect_merge, // Vendor bit
  output logic random_self_seek_mode, // Vendor bit
  output logic recovered_nondata_report, // Vendor bit
  output logic format_degraded_report_disable, // Vendor bit
  output logic queue_aging_enable, // Vendor bit
  output logic reassigned_block_ignore, // Vendor bit
  output logic retry_count_limit_mode, // Vendor bit
  output logic [7:0] temp_threshold, // Vendor byte
  output logic restore_before_reassign_disable, // Vendor bit
  output logic fast_format_enable, // Vendor bit
  output logic format_certify_enable // Vendor bit
);
  import mpd_pkg::*;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  mpd_vp_if vp ();
  mpd_vendor_page u_vp (.clk(clk), .rst_b(rst_b), .vp(vp.store));

  logic [63:0] cnt_r; // Collected block count
  logic [31:0] len_r; // Collected block length
  logic [63:0] blocks_r; // Addressable blocks
  logic [31:0] len_cur_r; // Block length in use
  logic cnt_ok;
  logic len_ok;
  logic len_change;

  mpd_len_check u_chk (
    .cnt(cnt_r),
    .len(len_r),
    .max_blocks(max_blocks),
    .cur_len(len_cur_r),
    .cnt_ok(cnt_ok),
    .len_ok(len_ok),
    .len_change(len_change)
  );

  // ----------------------------------------
  // Select parser state
  // ----------------------------------------
  mpd_sel_t st_r, st_nxt; // Parser state
  logic [3:0] d_idx_r; // Descriptor byte index
  logic wide_r; // Long descriptor in this list
  logic desc_r; // List carries a descriptor
  logic [5:0] pg_r; // Page being parsed
  logic [7:0] b_cnt_r; // Body bytes left
  logic bdl_bad; // Descriptor length unusable
  logic dlast; // Final descriptor byte
  logic pg0_bad; // Page header refused
  logic ok_end; // List ends cleanly
  logic live; // List in progress

  // Length must agree with the wide flag
  assign bdl_bad = (sel_bd_len != BDL_NONE) &&
    (sel_bd_len != (sel_wide ? BDL_LONG : BDL_SHORT));
  assign dlast = d_idx_r == (wide_r ? LD_LAST : SD_LAST);
  // Subpage format is not served, so a set flag is refused
  assign pg0_bad = sel_data[6] ||
    (mpd_page_len(sel_data[5:0]) == 8'h00);
  assign live = st_r != SL_IDLE;
  assign ok_end = (st_r == SL_PG0) && (!desc_r || (cnt_ok && len_ok));

  // Next parser state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SL_IDLE: begin
        if (sel_start) begin
          st_nxt = bdl_bad ? SL_SKIP :
            (sel_bd_len == BDL_NONE ? SL_PG0 : SL_DESC);
        end
      end
      SL_DESC: begin
        if (sel_valid && dlast) begin
          st_nxt = SL_PG0;
        end
      end
      SL_PG0: begin
        if (sel_valid) begin
          st_nxt = pg0_bad ? SL_SKIP : SL_PG1;
        end
      end
      SL_PG1: begin
        if (sel_valid) begin
          st_nxt = (sel_data != mpd_page_len(pg_r)) ? SL_SKIP : SL_BODY;
        end
      end
      SL_BODY: begin
        if (sel_valid && b_cnt_r == 8'h01) begin
          st_nxt = SL_PG0;
        end
      end
      SL_SKIP: st_nxt = SL_SKIP; // Drain until list end
      default: st_nxt = SL_IDLE;
    endcase
    if (sel_end && live) begin
      st_nxt = SL_IDLE;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= SL_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // List context taken at start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wide_r <= 1'b0;
      desc_r <= 1'b0;
    end else if (st_r == SL_IDLE && sel_start) begin
      wide_r <= sel_wide;
      desc_r <= sel_bd_len != BDL_NONE;
    end
  end

  // Descriptor collection; reserved bytes are skipped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d_idx_r <= 4'h0;
      cnt_r <= 64'h0000_0000_0000_0000;
      len_r <= 32'h0000_0000;
    end else if (st_r == SL_IDLE) begin
      d_idx_r <= 4'h0;
      cnt_r <= 64'h0000_0000_0000_0000;
      len_r <= 32'h0000_0000;
    end else if (st_r == SL_DESC && sel_valid) begin
      d_idx_r <= d_idx_r + 4'h1;
      if (d_idx_r < (wide_r ? LD_CNTN : SD_CNTN)) begin
        cnt_r <= {cnt_r[55:0], sel_data};
      end else if (d_idx_r >= (wide_r ? LD_LEN0 : SD_LEN0)) begin
        len_r <= {len_r[23:0], sel_data};
      end
    end
  end

  // Page header and body counting
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pg_r <= 6'h00;
      b_cnt_r <= 8'h00;
    end else if (sel_valid) begin
      if (st_r == SL_PG0) begin
        pg_r <= sel_data[5:0];
      end else if (st_r == SL_PG1) begin
        b_cnt_r <= sel_data;
      end else if (st_r == SL_BODY) begin
        b_cnt_r <= b_cnt_r - 8'h01;
      end
    end
  end

  // Vendor bytes go to staging and become live only on a clean end
  assign vp.wr_en = sel_valid && st_r == SL_BODY && pg_r == 6'h00;
  assign vp.wr_idx = 4'(8'h10 - b_cnt_r);
  assign vp.wr_data = sel_data;
  assign vp.commit = sel_end && live && ok_end;
  assign vp.abort = sel_end && live && !ok_end;

  // Select completion pulses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_done <= 1'b0;
      sel_chk <= 1'b0;
    end else begin
      sel_done <= sel_end && live;
      sel_chk <= sel_end && live && !ok_end;
    end
  end

  // ----------------------------------------
  // Capacity and block length
  // ----------------------------------------
  logic init_r; // Capacity loaded after reset
  logic pend_r; // Values wait for a format
  logic [63:0] pend_cnt_r; // Waiting count
  logic [31:0] pend_len_r; // Waiting length

  // Capacity strap is caught on the first clock after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      init_r <= 1'b0;
      blocks_r <= 64'h0000_0000_0000_0000;
      len_cur_r <= BLEN_RST;
      pend_r <= 1'b0;
      pend_cnt_r <= 64'h0000_0000_0000_0000;
      pend_len_r <= BLEN_RST;
    end else if (!init_r) begin
      init_r <= 1'b1;
      blocks_r <= max_blocks;
    end else begin
      if (fmt_start && pend_r) begin
        pend_r <= 1'b0;
        len_cur_r <= pend_len_r;
        blocks_r <= (pend_cnt_r == 64'h0000_0000_0000_0000) ?
          blocks_r : pend_cnt_r;
      end
      if (vp.commit && desc_r) begin
        if (len_change) begin
          pend_r <= 1'b1;
          pend_cnt_r <= cnt_r;
          pend_len_r <= len_r;
        end else if (cnt_r != 64'h0000_0000_0000_0000) begin
          blocks_r <= cnt_r;
        end
      end
    end
  end

  assign fmt_pending = pend_r;
  assign user_blocks = blocks_r;
  assign cur_len = len_cur_r;

  // ----------------------------------------
  // Sense data stream
  // ----------------------------------------
  logic s_busy_r; // Stream running
  logic [5:0] s_idx_r; // Byte being offered
  logic [5:0] s_tot_r; // Bytes in stream minus one
  logic [4:0] s_dlen_r; // Descriptor bytes
  logic [5:0] s_pg_r; // Page served
  logic [4:0] s_dlen;
  logic [5:0] s_nidx;

  // Byte i of the sense stream; short count saturates when too large
  function automatic logic [7:0] sb(input logic [5:0] i,
    input logic [4:0] dl, input logic [5:0] c);
    logic [31:0] sc;
    logic [5:0] j;
    sc = (blocks_r[63:32] != 32'h0000_0000) ? 32'hFFFF_FFFF : blocks_r[31:0];
    j = i - 6'(dl);
    if (i < 6'(dl)) begin
      if (dl == 5'h08) begin
        if (i < 6'h04) return sc[8'(6'h03 - i) * 8 +: 8];
        else if (i == 6'h04) return 8'h00;
        else return len_cur_r[8'(6'h07 - i) * 8 +: 8];
      end else begin
        if (i < 6'h08) return blocks_r[8'(6'h07 - i) * 8 +: 8];
        else if (i < 6'h0C) return 8'h00;
        else return len_cur_r[8'(6'h0F - i) * 8 +: 8];
      end
    end else if (j == 6'h00) begin
      return {mpd_savable(c), 1'b0, c};
    end else if (j == 6'h01) begin
      return mpd_page_len(c);
    end else if (c == 6'h00) begin
      return vp.page[j[3:0]];
    end else begin
      return 8'h00; // Bodies of other pages are sent as zeros
    end
  endfunction

  assign s_dlen = sense_no_desc ? 5'h00 : (sense_wide ? 5'h10 : 5'h08);
  assign s_nidx = s_idx_r + 6'h01;

  // Stream control; data and last are registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_busy_r <= 1'b0;
      s_idx_r <= 6'h00;
      s_tot_r <= 6'h00;
      s_dlen_r <= 5'h00;
      s_pg_r <= 6'h00;
      so_data <= 8'h00;
      so_last <= 1'b0;
      sense_chk <= 1'b0;
    end else begin
      sense_chk <= 1'b0;
      if (!s_busy_r && sense_start) begin
        if (mpd_page_len(sense_code) == 8'h00) begin
          sense_chk <= 1'b1;
        end else begin
          s_busy_r <= 1'b1;
          s_idx_r <= 6'h00;
          s_dlen_r <= s_dlen;
          s_pg_r <= sense_code;
          s_tot_r <= 6'(s_dlen) + 6'(mpd_page_len(sense_code)) + 6'h01;
          so_data <= sb(6'h00, s_dlen, sense_code);
          so_last <= 1'b0;
        end
      end else if (s_busy_r && so_ready) begin
        if (so_last) begin
          s_busy_r <= 1'b0;
          so_last <= 1'b0;
        end else begin
          s_idx_r <= s_nidx;
          so_data <= sb(s_nidx, s_dlen_r, s_pg_r);
          so_last <= s_nidx == s_tot_r;
        end
      end
    end
  end

  assign so_valid = s_busy_r;

  // ----------------------------------------
  // Vendor fields and timers
  // ----------------------------------------
  logic [31:0] unit_cnt_r; // Divider to 50 ms units
  logic unit_tick;
  logic [11:0] overall_command_timer; // Command timer limit
  logic [11:0] cmd_units_r; // Units the command has run
  logic fired_r; // Abort already given
  logic [15:0] age_units_r; // Units spent waiting

  assign grown_defect_merge = vp.page[VP_MRG_B][VP_MRG_I];
  assign random_self_seek_mode = vp.page[VP_SEEK_B][VP_SEEK_I];
  assign recovered_nondata_report = vp.page[VP_SEEK_B][VP_RRN_I];
  assign format_degraded_report_disable = vp.page[VP_FDD_B][VP_FDD_I];
  assign queue_aging_enable = vp.page[VP_FDD_B][VP_AGE_I];
  assign reassigned_block_ignore = vp.page[VP_OCTH_B][VP_IGR_I];
  assign retry_count_limit_mode = vp.page[VP_OCTH_B][VP_RCL_I];
  assign temp_threshold = vp.page[VP_TEMP_B];
  assign restore_before_reassign_disable = vp.page[VP_DR_B][VP_DRR_I];
  assign fast_format_enable = vp.page[VP_DR_B][VP_FF_I];
  assign format_certify_enable = vp.page[VP_FC_B][VP_FC_I];
  assign overall_command_timer = {vp.page[VP_OCTH_B][3:0], vp.page[VP_OCTL_B]};
  assign unit_tick = unit_cnt_r == 32'(UNIT_CYCLES - 1);

  // Free divider: the first unit of a command may be short
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unit_cnt_r <= 32'h0000_0000;
    end else begin
      unit_cnt_r <= unit_tick ? 32'h0000_0000 : unit_cnt_r + 32'h0000_0001;
    end
  end

  // Overall command timer, one abort per command
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_units_r <= 12'h000;
      fired_r <= 1'b0;
      cmd_abort <= 1'b0;
    end else if (!cmd_active) begin
      cmd_units_r <= 12'h000;
      fired_r <= 1'b0;
      cmd_abort <= 1'b0;
    end else begin
      if (unit_tick && cmd_units_r != 12'hFFF) begin
        cmd_units_r <= cmd_units_r + 12'h001;
      end
      cmd_abort <= !fired_r && overall_command_timer != 12'h000 && cmd_units_r >= overall_command_timer;
      if (overall_command_timer != 12'h000 && cmd_units_r >= overall_command_timer) begin
        fired_r <= 1'b1;
      end
    end
  end

  // Queue aging: wait measured while a command is queued
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      age_units_r <= 16'h0000;
      age_expired <= 1'b0;
    end else if (!queue_wait) begin
      age_units_r <= 16'h0000;
      age_expired <= 1'b0;
    end else begin
      if (unit_tick && age_units_r != 16'hFFFF) begin
        age_units_r <= age_units_r + 16'h0001;
      end
      age_expired <= queue_aging_enable &&
        age_units_r > {vp.page[VP_AGEH_B], vp.page[VP_AGEL_B]};
    end
  end
endmodule // mpd_core

/* inc/mpd_pkg.sv */
// Constants, field layouts and page tables for the mode descriptor block.
// Assumes a single 10 MHz clock domain and byte-wide parameter streams.
//
// Function
// - Short descriptor: count 0-3, length 5-7
// - Long descriptor: count 0-7, length 12-15
// - Zero block count leaves capacity unchanged
// - Count equal to full capacity is accepted
// - Smaller count trims the addressable space
// - Larger block count ends with check condition
// - Sense reports the current user block count
// - Only listed block lengths are accepted; the core also accepts zero, which keeps the length in use
// - Block length counts user bytes only
// - Length change waits for a format command
// - Page header: flags and code, then length
// - Sense savable flag set for storable pages
// - Subpage flag picks short or long format; the core refuses a set flag
// - Supported page codes; pages 03, 04 unsavable
// - Page length mismatch ends with check condition
// - Vendor page code 00, length 0Eh
// - Vendor byte 5 holds two bits, default 02h
// - Vendor bytes 6-7 hold bits and timer
// - Byte 9 threshold, bytes 10-11 aging limit
// - Vendor byte 14 holds two bits, default 00h
// - Ignored vendor bits stored but never used
// - Descriptor length 0, 8 or 16
// - Wide flag selects the long descriptor
// - Command timer in 50 ms units, zero off
// - Aging limit bounds queue wait, 50 ms units
package mpd_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000; // Core clock rate
  localparam int UNIT_MS = 50; // Timer unit in milliseconds
  localparam int UNIT_CYC = UNIT_MS * (CLK_HZ / 1000); // Cycles per unit

  // ----------------------------------------
  // Descriptor layout
  // ----------------------------------------
  localparam logic [15:0] BDL_NONE = 16'h0000; // No descriptor
  localparam logic [15:0] BDL_SHORT = 16'h0008; // Short descriptor
  localparam logic [15:0] BDL_LONG = 16'h0010; // Long descriptor
  localparam logic [3:0] SD_LAST = 4'h7; // Last short byte
  localparam logic [3:0] LD_LAST = 4'hF; // Last long byte
  localparam logic [3:0] SD_LEN0 = 4'h5; // First short length byte
  localparam logic [3:0] LD_LEN0 = 4'hC; // First long length byte
  localparam logic [3:0] SD_CNTN = 4'h4; // Short count bytes
  localparam logic [3:0] LD_CNTN = 4'h8; // Long count bytes
  localparam logic [31:0] BLEN_A = 32'h0000_1000; // 4096
  localparam logic [31:0] BLEN_B = 32'h0000_1010; // 4112
  localparam logic [31:0] BLEN_C = 32'h0000_1040; // 4160
  localparam logic [31:0] BLEN_D = 32'h0000_1080; // 4224
  localparam logic [31:0] BLEN_RST = BLEN_A; // Length after reset

  // ----------------------------------------
  // Vendor page fields: byte index, bit index
  // ----------------------------------------
  localparam int VP_MRG_B = 2, VP_MRG_I = 3;
  localparam int VP_SEEK_B = 3, VP_SEEK_I = 6, VP_RRN_I = 1;
  localparam int VP_FDD_B = 5, VP_FDD_I = 4, VP_AGE_I = 1;
  localparam int VP_OCTH_B = 6, VP_IGR_I = 7, VP_RCL_I = 6;
  localparam int VP_OCTL_B = 7, VP_TEMP_B = 9;
  localparam int VP_AGEH_B = 10, VP_AGEL_B = 11;
  localparam int VP_DR_B = 14, VP_DRR_I = 7, VP_FF_I = 5;
  localparam int VP_FC_B = 15, VP_FC_I = 5;
  localparam logic [15:0][7:0] VP_DEF = {8'h00, 8'h00, 8'h14, 8'h16,
    8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00,
    8'h00, 8'h0E, 8'h80}; // Bytes 15 down to 0

  // Page length reported per code; zero marks an unsupported code
  function automatic logic [7:0] mpd_page_len(input logic [5:0] c);
    unique case (c)
      6'h00: return 8'h0E;
      6'h01, 6'h07, 6'h0A, 6'h1C: return 8'h0A;
      6'h02, 6'h19: return 8'h0E;
      6'h03, 6'h04, 6'h0C: return 8'h16;
      6'h08: return 8'h12;
      6'h1A: return 8'h26;
      default: return 8'h00;
    endcase
  endfunction

  // Pages 03 and 04 cannot be kept in the reserved area
  function automatic logic mpd_savable(input logic [5:0] c);
    return (c != 6'h03) && (c != 6'h04);
  endfunction

  typedef enum logic [2:0] {
    SL_IDLE = 3'b000, SL_DESC = 3'b001, SL_PG0 = 3'b010,
    SL_PG1 = 3'b011, SL_BODY = 3'b100, SL_SKIP = 3'b101
  } mpd_sel_t;
endpackage

/* inc/mpd_vp_if.sv */
// Link between the command core and the vendor page store.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface mpd_vp_if;
  logic wr_en; // Stage one byte
  logic [3:0] wr_idx; // Byte index 2..15
  logic [7:0] wr_data; // Byte value
  logic commit; // Staged bytes become live
  logic abort; // Staged bytes fall back to live
  logic [15:0][7:0] page; // Live page bytes
  modport core (output wr_en, wr_idx, wr_data, commit, abort, input page);
  modport store (input wr_en, wr_idx, wr_data, commit, abort, output page);
endinterface

/* core/mpd_vendor_page.sv */
// Vendor page store: live copy plus a staging copy.
// Assumes commit and abort never come in the same cycle.
`timescale 1ns/1ns
module mpd_vendor_page (
  input wire logic clk, // Core clock
  input wire logic rst_b, // Async reset, active low
  mpd_vp_if.store vp // Core side
);
  import mpd_pkg::*;

  logic [15:0][7:0] live_r; // Bytes in use
  logic [15:0][7:0] stage_r; // Bytes of a list still in flight

  // ----------------------------------------
  // Staging copy
  // ----------------------------------------
  // Staging keeps a failed list from touching live values
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_r <= VP_DEF;
    end else if (vp.abort) begin
      stage_r <= live_r;
    end else if (vp.wr_en && vp.wr_idx > 4'h1) begin
      stage_r[vp.wr_idx] <= vp.wr_data;
    end
  end

  // ----------------------------------------
  // Live copy
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      live_r <= VP_DEF;
    end else if (vp.commit) begin
      live_r <= stage_r;
    end
  end

  assign vp.page = live_r;
endmodule // mpd_vendor_page

/* core/mpd_len_check.sv */
// Block count and block length checks for one descriptor.
// Pure logic; the core samples the result at list end.
`timescale 1ns/1ns
module mpd_len_check (
  input wire logic [63:0] cnt, // Requested block count
  input wire logic [31:0] len, // Requested block length
  input wire logic [63:0] max_blocks, // Blocks in the data area
  input wire logic [31:0] cur_len, // Block length in use
  output logic cnt_ok, // Count acceptable
  output logic len_ok, // Length acceptable
  output logic len_change // Length needs a format
);
  import mpd_pkg::*;

  // Zero, full capacity or less all pass
  assign cnt_ok = (cnt <= max_blocks);
  // User bytes only, so the protected 4096 form is plain 4096
  assign len_ok = (len == 32'h0000_0000) || (len == BLEN_A) ||
    (len == BLEN_B) || (len == BLEN_C) || (len == BLEN_D);
  assign len_change = (len != 32'h0000_0000) && (len != cur_len);
endmodule // mpd_len_check

/* testbench/mpd_core_sva.sv */
// Port checker for the mode descriptor core.
// Assumes binding from the bench top; one clock domain.
`timescale 1ns/1ns
module mpd_core_sva (
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic sel_end, // List end
  input wire logic sel_done, // Select done
  input wire logic sel_chk, // Select failed
  input wire logic fmt_start, // Format pulse
  input wire logic fmt_pending, // Awaits format
  input wire logic [31:0] cur_len, // Length in use
  input wire logic sense_start, // Sense pulse
  input wire logic [5:0] sense_code, // Page asked
  input wire logic sense_chk, // Bad page
  input wire logic so_valid, // Byte valid
  input wire logic so_ready, // Byte taken
  input wire logic [7:0] so_data // Byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Done is a single-cycle answer
  sequence s_ans;
    sel_done ##1 !sel_done;
  endsequence
  property p_done; sel_end |=> s_ans; endproperty
  a_done: assert property (p_done) else $error("select not answered");
  property p_chk; sel_chk |-> sel_done; endproperty
  a_chk: assert property (p_chk) else $error("check without done");
  property p_len; cur_len inside {32'h0000_1000, 32'h0000_1010, 32'h0000_1040,
    32'h0000_1080}; endproperty
  a_len: assert property (p_len) else $error("illegal length in use");
  // Length only moves after a list end or a format
  property p_cur; $changed(cur_len) |-> $past(sel_end) || $past(fmt_start); endproperty
  a_cur: assert property (p_cur) else $error("length moved alone");
  property p_fmt; fmt_start && fmt_pending |=> !fmt_pending; endproperty
  a_fmt: assert property (p_fmt) else $error("format left pending");
  property p_code; sense_start && !so_valid && sense_code == 6'h05 |=> sense_chk && !so_valid;
  endproperty
  a_code: assert property (p_code) else $error("bad page not refused");
  property p_ans; sense_start && !so_valid |=> so_valid ^ sense_chk; endproperty
  a_ans: assert property (p_ans) else $error("sense not answered");
  property p_hold; so_valid && !so_ready |=> so_valid && $stable(so_data); endproperty
  a_hold: assert property (p_hold) else $error("sense byte dropped");
endmodule // mpd_core_sva

/* testbench/mpd_host.sv */
// Initiator model: takes sense bytes, stalls when slow.
// Assumes the core clock.
`timescale 1ns/1ns
module mpd_host (
  input wire logic clk, // Clock
  input wire logic slow, // Stall every other cycle
  input wire logic so_valid, // Byte valid
  input wire logic [7:0] so_data, // Byte
  output logic so_ready // Byte taken
);
  logic [7:0] got[$]; // Bytes taken
  initial so_ready = 1'b0;
  // Hand-off only at an edge with ready high
  always @(posedge clk) begin
    so_ready <= slow ? !so_ready : 1'b1;
    if (so_valid && so_ready) got.push_back(so_data);
  end
endmodule // mpd_host

/* testbench/mode_param_descriptor_check_test.sv */
// Self-checking bench for the mode descriptor core.
// Assumes inputs move 5 ns after each rising edge.
`timescale 1ns/1ns
module mode_param_descriptor_check_test;
  logic clk = 0, rst_b = 0, sel_start = 0, sel_wide = 0, sel_valid = 0, sel_end = 0;
  logic fmt_start = 0, sense_start = 0, sense_wide = 0, sense_no_desc = 0, slow = 0;
  logic [15:0] sel_bd_len = 0;
  logic [7:0] sel_data = 0, so_data, temp;
  logic [5:0] sense_code = 0;
  logic [63:0] max_blocks = 64'd1000, user_blocks;
  logic [31:0] cur_len;
  logic sel_done, sel_chk, fmt_pending, sense_chk, so_valid, so_last, so_ready, fdd, qae;
  logic [7:0] bq[$]; // Select list bytes
  logic cmd_active = 0, queue_wait = 0, cmd_abort, age_expired;
  int n_errors = 0, comparisons = 0, cyc = 0, n_abort = 0;
  mpd_core #(.UNIT_CYCLES(4)) i_dut (.clk, .rst_b, .max_blocks, .sel_start, .sel_wide,
    .sel_bd_len, .sel_valid, .sel_data, .sel_end, .sel_done, .sel_chk, .fmt_start,
    .fmt_pending, .user_blocks, .cur_len, .sense_start, .sense_wide, .sense_no_desc,
    .sense_code, .sense_chk, .so_valid, .so_data, .so_last, .so_ready,
    .cmd_active, .cmd_abort, .queue_wait, .age_expired,
    .grown_defect_merge(), .random_self_seek_mode(), .recovered_nondata_report(),
    .format_degraded_report_disable(fdd), .queue_aging_enable(qae),
    .reassigned_block_ignore(), .retry_count_limit_mode(), .temp_threshold(temp),
    .restore_before_reassign_disable(), .fast_format_enable(), .format_certify_enable());
  mpd_host h (.clk, .slow, .so_valid, .so_data, .so_ready);
  initial forever #50 clk = ~clk;
  task automatic ck(input logic [127:0] g, input logic [127:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One select list, then its answer
  task automatic sel(input logic w, input logic [15:0] bl, input logic e);
    @(posedge clk) #5;
    sel_start = 1;
    sel_wide = w;
    sel_bd_len = bl;
    foreach (bq[i]) begin
      @(posedge clk) #5;
      sel_start = 0;
      sel_valid = 1;
      sel_data = bq[i];
    end
    @(posedge clk) #5;
    sel_valid = 0;
    sel_end = 1;
    @(posedge clk) #5;
    sel_end = 0;
    ck(sel_done, 1);
    ck(sel_chk, e);
  endtask
  // One sense request, bytes land in the host queue
  task automatic sns(input logic nd, input logic [5:0] c, input logic e);
    h.got.delete();
    @(posedge clk) #5;
    sense_start = 1;
    sense_no_desc = nd;
    sense_code = c;
    @(posedge clk) #5;
    sense_start = 0;
    ck(sense_chk, e);
    for (int i = 0; i < 99 && !(so_valid && so_ready && so_last); i++) @(posedge clk) #5;
    @(posedge clk) #5;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #5 rst_b = 1;
    repeat (2) @(posedge clk) #5;
    ck({qae, user_blocks}, {1'b1, 64'd1000});
    queue_wait = 1;
    repeat (200) @(posedge clk) #5;
    ck(age_expired, 1);
    bq = {8'h00, 8'h0E};
    for (int i = 2; i < 16; i++) bq.push_back(i == 5 ? 8'h10 : i == 9 ? 8'h55 : 8'h00);
    bq[7] = 8'h02;
    sel(0, 0, 0);
    ck({fdd, qae, temp}, {2'b10, 8'h55});
    cmd_active = 1;
    repeat (20) @(posedge clk) #5 n_abort += cmd_abort;
    ck(n_abort, 1);
    sns(1, 6'h00, 0);
    ck({h.got[0], h.got[1], h.got[5], h.got[9]}, 32'h800E_1055);
    bq = {8'h00, 8'h00, 8'h01, 8'hF4, 8'h00, 8'h00, 8'h10, 8'h00};
    sel(0, 8, 0);
    ck({fmt_pending, user_blocks}, 64'd500);
    bq[2] = 8'h00;
    bq[3] = 8'h00;
    sel(0, 8, 0);
    ck(user_blocks, 64'd500);
    bq[2] = 8'h03;
    bq[3] = 8'hE9;
    sel(0, 8, 1);
    bq[2] = 8'h00;
    bq[3] = 8'h00;
    bq[7] = 8'h04;
    sel(0, 8, 1);
    bq = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'hE8, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h10, 8'h40};
    sel(1, 16, 0);
    ck({fmt_pending, cur_len}, {1'b1, 32'h0000_1000});
    @(posedge clk) #5;
    fmt_start = 1;
    @(posedge clk) #5;
    fmt_start = 0;
    ck({fmt_pending, cur_len, user_blocks}, {1'b0, 32'h0000_1040, 64'd1000});
    bq = {8'h01, 8'h0B};
    repeat (11) bq.push_back(8'h00);
    sel(0, 0, 1);
    bq[0] = 8'h05;
    sel(0, 0, 1);
    sense_wide = 1;
    sns(0, 6'h03, 0);
    ck({h.got[16], h.got[17]}, 16'h0316);
    slow = 1;
    sense_wide = 0;
    sns(0, 6'h1C, 0);
    ck({h.got[0], h.got[1], h.got[2], h.got[3], h.got[4], h.got[5], h.got[6], h.got[7]},
      64'h0000_03E8_0000_1040);
    ck({h.got[8], h.got[9]}, 16'h9C0A);
    sns(1, 6'h05, 1);
    report_and_stop();
  end
endmodule // mode_param_descriptor_check_test
bind mpd_core mpd_core_sva u_sva (.clk(clk), .rst_b(rst_b), .sel_end(sel_end),
  .sel_done(sel_done), .sel_chk(sel_chk), .fmt_start(fmt_start), .fmt_pending(fmt_pending),
  .cur_len(cur_len), .sense_start(sense_start), .sense_code(sense_code),
  .sense_chk(sense_chk), .so_valid(so_valid), .so_ready(so_ready), .so_data(so_data));
